// [rtl/ind_access_pkg.sv]
// Constants for the indirect register access window.
`default_nettype none
package ind_access_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int WORD_BYTES = 4;
    // Each register owns one aligned bus word, so its byte address is four times its index.
    localparam int CTRL_IDX = 32'hb0;
    localparam int OFFSET_IDX = 32'hb1;
    localparam int DATA_IDX = 32'hb2;
    localparam logic [ADDR_W-1:0] CTRL_OFFS = ADDR_W'(CTRL_IDX * WORD_BYTES);
    localparam logic [ADDR_W-1:0] OFFSET_OFFS = ADDR_W'(OFFSET_IDX * WORD_BYTES);
    localparam logic [ADDR_W-1:0] DATA_OFFS = ADDR_W'(DATA_IDX * WORD_BYTES);
    localparam int SEL_MSB = 4;
    localparam int SEL_LSB = 2;
    localparam int SEL_W = 3;
    localparam int AUTO_INC_BIT = 1;
    localparam int READ_GEN_BIT = 0;
    localparam logic [REG_W-1:0] CTRL_WMASK = 8'h1f;
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [REG_W-1:0] OFFSET_RESET = 8'h00;
    localparam logic [REG_W-1:0] OFFSET_STEP = 8'h01;
    localparam logic [SEL_W-1:0] PAGE_PATTERN = 3'h0;
    localparam logic [SEL_W-1:0] PAGE_LINK_TX = 3'h1;
    localparam int NUM_PAGES = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [rtl/page_decode.sv]
// Page select decoder: one-hot page enables from the control field.
`timescale 1ns/100ps
`default_nettype none
module page_decode
    import ind_access_pkg::*;
#(
    parameter int PAGES = NUM_PAGES
)
(
    // Selection
    input wire logic [SEL_W-1:0] sel,
    // Decoded enables
    output logic [PAGES-1:0] page_hit
);
    genvar g;
    generate
        for (g = 0; g < PAGES; g = g + 1)
        begin : g_hit
            assign page_hit[g] = (sel == SEL_W'(g));
        end
    endgenerate
endmodule // page_decode
`default_nettype wire

// [rtl/indirect_register_access_port.sv]
// Indirect register access window behind an AXI4-Lite slave.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module indirect_register_access_port
    import ind_access_pkg::*;
#(
    parameter int PAGES = NUM_PAGES
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // AXI4-Lite write address and data
    input wire logic [ind_access_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [ind_access_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [ind_access_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [ind_access_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Page side
    output logic [PAGES-1:0] PAGE_SEL,
    output logic [ind_access_pkg::REG_W-1:0] PAGE_OFFSET,
    output logic [ind_access_pkg::REG_W-1:0] PAGE_WDATA,
    output logic PAGE_WRITE,
    output logic PAGE_READ,
    input wire logic [ind_access_pkg::REG_W-1:0] PAGE_RDATA
);
    import ind_access_pkg::*;

    function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == CTRL_OFFS) ? 2'h1 : (a == OFFSET_OFFS) ? 2'h2 :
                  (a == DATA_OFFS) ? 2'h3 : 2'h0;
    endfunction

    logic aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [REG_W-1:0] w_data_reg;
    logic w_lane_reg;
    logic [REG_W-1:0] ctrl_reg;
    logic [REG_W-1:0] offset_reg;
    logic [REG_W-1:0] wdata_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic pwrite_reg, pread_reg;
    logic [PAGES-1:0] psel_reg;

    // A write completes once address and data are both held and no response waits.
    wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire [1:0] w_hit = reg_hit(aw_addr_reg);
    wire w_ok = (w_hit != 2'h0) && w_lane_reg;
    wire wr_ctrl = do_write && w_lane_reg && (w_hit == 2'h1);
    wire wr_offset = do_write && w_lane_reg && (w_hit == 2'h2);
    wire wr_data = do_write && w_lane_reg && (w_hit == 2'h3);
    wire do_read = S_AXI_ARVALID && arready_reg;
    wire [1:0] r_hit = reg_hit(S_AXI_ARADDR);
    wire rd_data = do_read && (r_hit == 2'h3);
    wire auto_inc = ctrl_reg[AUTO_INC_BIT];
    wire read_gen = ctrl_reg[READ_GEN_BIT];
    wire [SEL_W-1:0] page_sel = ctrl_reg[SEL_MSB:SEL_LSB];
    wire data_access = wr_data || rd_data;
    // An offset write wins over a same-cycle data access, which then does not step.
    wire [REG_W-1:0] offset_next = wr_offset ? w_data_reg :
        (auto_inc && data_access) ? REG_W'(offset_reg + OFFSET_STEP) : offset_reg;
    wire pread_next = (wr_offset && read_gen) || (rd_data && read_gen && auto_inc);
    wire [PAGES-1:0] psel_next;
    wire [REG_W-1:0] rd_byte = (r_hit == 2'h1) ? (ctrl_reg & CTRL_WMASK) :
                               (r_hit == 2'h2) ? offset_reg :
                               (r_hit == 2'h3) ? PAGE_RDATA : 8'h00;

    page_decode #(.PAGES(PAGES)) u_decode (
        .sel(page_sel),
        .page_hit(psel_next)
    );

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            awready_reg <= 1'b0;
        end
        else
        begin
            awready_reg <= !aw_held_reg && !(S_AXI_AWVALID && awready_reg) && !bvalid_reg;
            if (S_AXI_AWVALID && awready_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_lane_reg <= 1'b0;
            wready_reg <= 1'b0;
        end
        else
        begin
            wready_reg <= !w_held_reg && !(S_AXI_WVALID && wready_reg) && !bvalid_reg;
            if (S_AXI_WVALID && wready_reg)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA[REG_W-1:0];
                w_lane_reg <= S_AXI_WSTRB[0];
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
            bvalid_reg <= 1'b0;
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else
        begin
            arready_reg <= !rvalid_reg && !do_read;
            if (do_read)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
                rresp_reg <= (r_hit != 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_RREADY)
                rvalid_reg <= 1'b0;
        end
    end

    // Reserved control bits are never stored, so they cannot read back as one.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_reg <= CTRL_RESET;
            offset_reg <= OFFSET_RESET;
            wdata_reg <= '0;
            pwrite_reg <= 1'b0;
            pread_reg <= 1'b0;
            psel_reg <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= w_data_reg & CTRL_WMASK;
            offset_reg <= offset_next;
            if (wr_data)
                wdata_reg <= w_data_reg;
            pwrite_reg <= wr_data;
            pread_reg <= pread_next;
            psel_reg <= psel_next;
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign PAGE_WRITE = pwrite_reg;
    assign PAGE_READ = pread_reg;
    assign PAGE_WDATA = wdata_reg;
    assign PAGE_SEL = psel_reg;
    assign PAGE_OFFSET = offset_reg;

    a_offset_step: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (auto_inc && rd_data && !wr_offset) |=> offset_reg == $past(offset_reg) + OFFSET_STEP)
        else $error("offset did not step after data read");
    a_offset_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (!auto_inc && !wr_offset) |=> offset_reg == $past(offset_reg))
        else $error("offset moved without cause");
    a_offset_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr_offset |=> PAGE_OFFSET == $past(w_data_reg))
        else $error("offset write lost");
    a_strobe_offset: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (wr_offset && read_gen) |=> PAGE_READ)
        else $error("no read strobe on offset write");
    a_strobe_cause: assert property (@(posedge MCLK) disable iff (SYS_RST)
        PAGE_READ |-> $past(read_gen) && ($past(wr_offset) || $past(rd_data && auto_inc)))
        else $error("read strobe without cause");
    a_page_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr_data |=> PAGE_WRITE && PAGE_WDATA == $past(w_data_reg))
        else $error("page write missing");
    a_ctrl_reserved: assert property (@(posedge MCLK) disable iff (SYS_RST)
        ctrl_reg[REG_W-1:SEL_MSB+1] == '0)
        else $error("reserved control bits set");
    a_page_sel: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr_ctrl && w_data_reg[SEL_MSB:SEL_LSB] == PAGE_LINK_TX ##2 1'b1 |-> PAGE_SEL[1])
        else $error("link page not selected");
    a_read_data: assert property (@(posedge MCLK) disable iff (SYS_RST)
        rd_data |=> S_AXI_RVALID && S_AXI_RDATA[REG_W-1:0] == $past(PAGE_RDATA))
        else $error("data read mismatch");
endmodule // indirect_register_access_port
`default_nettype wire

// [sim/page_model.sv]
// Page-side model: two register pages answering the access window.
`timescale 1ns/100ps
`default_nettype none
module page_model
    import ind_access_pkg::*;
(
    // Clock
    input wire logic clk,
    // Page interface
    input wire logic [1:0] sel,
    input wire logic [REG_W-1:0] offset,
    input wire logic [REG_W-1:0] wdata,
    input wire logic write,
    output logic [REG_W-1:0] rdata
);
    logic [REG_W-1:0] mem [2][256];
    logic [REG_W-1:0] off_d;
    logic [REG_W-1:0] noise = 8'h00;
    // Pages start cleared, so a read of an untouched offset still returns known data.
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem[0][i] = '0;
            mem[1][i] = '0;
        end
    end
    // The offset may step with the strobe, so a write uses the one seen a cycle earlier.
    always @(posedge clk)
    begin
        off_d <= offset;
        noise <= noise + 8'h3b;
        if (write && sel != 2'b00)
            mem[sel[1]][off_d] <= wdata;
    end
    // An unselected bus is not driven, so it shows a changing pattern instead of old data.
    assign rdata = (sel == 2'b00) ? noise : mem[sel[1]][offset];
endmodule // page_model
`default_nettype wire

// [sim/test_indirect_register_access_port.sv]
// Self-checking bench for the indirect register access window.
`timescale 1ns/100ps
`default_nettype none
module test_indirect_register_access_port;
    import ind_access_pkg::*;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [ADDR_W-1:0] awa = 0, ara = 0;
    logic [7:0] prd, poff, pwd, o;
    logic [31:0] wd = 0, rdat, x;
    logic [3:0] ws = 0;
    logic awr, wrr, bv, arr, rv, pw, pr;
    logic [1:0] br, rr, psel, r;
    logic [2:0] p;
    logic [7:0] q [3];
    int failures = 0, n_tests = 0, nrd = 0, base;
    indirect_register_access_port uut (.MCLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .PAGE_SEL(psel), .PAGE_OFFSET(poff), .PAGE_WDATA(pwd), .PAGE_WRITE(pw),
        .PAGE_READ(pr), .PAGE_RDATA(prd));
    page_model part (.clk(clk), .sel(psel), .offset(poff), .wdata(pwd), .write(pw),
        .rdata(prd));
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (pr === 1'b1)
            nrd <= nrd + 1;
    function automatic logic [7:0] ctl(input logic [2:0] s, input logic ai, input logic rg);
        return {3'b000, s, ai, rg};
    endfunction
    function automatic logic [1:0] hot(input logic [2:0] s);
        return (s == PAGE_PATTERN) ? 2'b01 : (s == PAGE_LINK_TX) ? 2'b10 : 2'b00;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Each channel is released only at the edge that takes it; the answer is awaited.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] rs);
        bit done;
        done = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        while (!done)
        begin
            @(posedge clk);
            if (awr === 1'b1)
                awv <= 0;
            if (wrr === 1'b1)
                wv <= 0;
            if (bv === 1'b1)
            begin
                rs = br;
                bry <= 0;
                done = 1;
            end
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] rs);
        bit done;
        done = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rry <= 1;
        while (!done)
        begin
            @(posedge clk);
            if (arr === 1'b1)
                arv <= 0;
            if (rv === 1'b1)
            begin
                d = rdat;
                rs = rr;
                rry <= 0;
                done = 1;
            end
        end
    endtask
    task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        wr(a, d, 4'hf, r);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        rd(a, x, r);
        chk(x, exp);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(45357));
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        rdc(CTRL_OFFS, 32'(CTRL_RESET));
        w(CTRL_OFFS, 32'hffff_ffff);
        rdc(CTRL_OFFS, 32'h1f);
        for (int s = 0; s < 4; s++)
        begin
            w(CTRL_OFFS, 32'(ctl(s[2:0], 0, 0)));
            repeat (2) @(posedge clk);
            chk(32'(psel), 32'(hot(s[2:0])));
        end
        $display("reset and select done");
        for (int k = 0; k < 8; k++)
        begin
            p = 3'(k % 2);
            o = 8'($urandom);
            q[0] = 8'($urandom);
            w(CTRL_OFFS, 32'(ctl(p, 0, 0)));
            w(OFFSET_OFFS, {$urandom} << 8 | 32'(o));
            rdc(OFFSET_OFFS, 32'(o));
            w(DATA_OFFS, 32'(q[0]));
            repeat (2) @(posedge clk);
            chk(32'(part.mem[p[0]][o]), 32'(q[0]));
            rdc(DATA_OFFS, 32'(q[0]));
            rdc(OFFSET_OFFS, 32'(o));
        end
        $display("single access done");
        // The burst starts one below the top so the offset has to wrap.
        w(CTRL_OFFS, 32'(ctl(1, 1, 0)));
        w(OFFSET_OFFS, 32'hfe);
        for (int i = 0; i < 3; i++)
        begin
            q[i] = 8'($urandom);
            w(DATA_OFFS, 32'(q[i]));
        end
        rdc(OFFSET_OFFS, 32'h01);
        rdc(CTRL_OFFS, 32'(ctl(1, 1, 0)));
        w(OFFSET_OFFS, 32'hfe);
        for (int i = 0; i < 3; i++)
            rdc(DATA_OFFS, 32'(q[i]));
        $display("auto increment done");
        w(CTRL_OFFS, 32'(ctl(0, 0, 0)));
        base = nrd;
        w(OFFSET_OFFS, 32'h10);
        rd(DATA_OFFS, x, r);
        chk(nrd - base, 0);
        w(CTRL_OFFS, 32'(ctl(0, 0, 1)));
        base = nrd;
        w(OFFSET_OFFS, 32'h10);
        repeat (2) @(posedge clk);
        chk(nrd - base, 1);
        w(CTRL_OFFS, 32'(ctl(0, 1, 1)));
        base = nrd;
        w(OFFSET_OFFS, 32'h10);
        rd(DATA_OFFS, x, r);
        rd(DATA_OFFS, x, r);
        repeat (2) @(posedge clk);
        chk(nrd - base, 3);
        $display("read strobes done");
        wr(ADDR_W'(32'hb3 * WORD_BYTES), 32'h5a, 4'hf, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(ADDR_W'(32'hb3 * WORD_BYTES), x, r);
        chk(x, 0);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(OFFSET_OFFS, 32'h77, 4'he, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rdc(OFFSET_OFFS, 32'h12);
        $display("error access done");
        end_of_test;
    end
endmodule // test_indirect_register_access_port
`default_nettype wire
